// [src/starter_self_test_sequencer.sv]
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module starter_self_test_sequencer (
	input  wire logic                     sys_clk,
	input  wire logic                     reset,
	input  wire logic [3:0]               regAddr,
	input  wire logic [31:0]              regWdata,
	input  wire logic                     regWrite,
	input  wire logic                     regRead,
	output logic [31:0]                   regRdata,
	input  wire logic                     disconnectClosed,
	input  wire logic                     linePowerPresent,
	input  wire logic                     enterKey,
	input  wire logic [7:0]               digitalIn,
	output self_test_pkg::drive_t         drive,
	output self_test_pkg::display_t       display,
	output logic [2:0]                    gateNum,
	output logic [7:0]                    eventNum,
	output logic                          eventPulse,
	output logic [7:0]                    faultCode,
	output logic                          systemReset
);

	// ****************************************************************
	// State
	// ****************************************************************
	self_test_pkg::state_all_t st_r;
	self_test_pkg::state_all_t st_nxt;

	// Outputs straight from the state flops
	assign regRdata    = st_r.rdata;
	assign drive       = st_r.drive;
	assign display     = st_r.display;
	assign gateNum     = st_r.gateNum;
	assign eventNum    = st_r.eventNum;
	assign eventPulse  = st_r.eventPulse;
	assign faultCode   = st_r.faultCode;
	assign systemReset = st_r.systemReset;

	// Helper terms from configuration, state and synchronised inputs
	logic [7:0] lineSel;
	logic [7:0] bypSel;
	logic       lineUsed;
	logic       bypUsed;
	logic       lineFb;
	logic       bypFb;
	logic       enterPress;
	logic       hv;
	logic       active;
	logic [31:0] lineLimit;
	logic [31:0] bypLimit;
	assign lineSel    = st_r.config_[self_test_pkg::CFG_LINE_SEL_LSB +: 8];
	assign bypSel     = st_r.config_[self_test_pkg::CFG_BYP_SEL_LSB +: 8];
	assign lineUsed   = |lineSel;
	assign bypUsed    = |bypSel;
	assign lineFb     = |(st_r.inSync & lineSel);
	assign bypFb      = |(st_r.inSync & bypSel);
	assign enterPress = st_r.enterSync[1] & ~st_r.enterPrev;
	assign hv         = st_r.config_[self_test_pkg::CFG_HV_BIT];
	assign active     = (st_r.state != self_test_pkg::S_IDLE)
		&& (st_r.state != self_test_pkg::S_DONE) && (st_r.state != self_test_pkg::S_HOLD);
	assign lineLimit  = {16'h0000, st_r.lineTmo};
	assign bypLimit   = {16'h0000, st_r.bypassTmo};

	// Gate of each sequential step: p1b, p1a, p2b, p2a, p3b, p3a
	function automatic logic [5:0] gateOf(input logic [2:0] step);
		logic [5:0] g;
		g = 6'h00;
		unique case (step)
			3'h0: g = 6'h02;
			3'h1: g = 6'h01;
			3'h2: g = 6'h08;
			3'h3: g = 6'h04;
			3'h4: g = 6'h20;
			default: g = 6'h10;
		endcase
		return g;
	endfunction

	// Displayed gate number in order 6,3,5,2,4,1
	function automatic logic [2:0] numOf(input logic [2:0] step);
		logic [2:0] n;
		n = 3'h0;
		unique case (step)
			3'h0: n = 3'h6;
			3'h1: n = 3'h3;
			3'h2: n = 3'h5;
			3'h3: n = 3'h2;
			3'h4: n = 3'h4;
			default: n = 3'h1;
		endcase
		return n;
	endfunction

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic advance;
		logic [31:0] dwell;
		advance = 1'b0;
		dwell   = 32'(self_test_pkg::DWELL_MS);
		st_nxt  = st_r;
		st_nxt.eventPulse  = 1'b0;
		st_nxt.systemReset = 1'b0;
		// Disconnect, line power, enter key and digital inputs through two flops before use; register port used directly
		st_nxt.discSync  = {st_r.discSync[0], disconnectClosed};
		st_nxt.powerSync = {st_r.powerSync[0], linePowerPresent};
		st_nxt.enterSync = {st_r.enterSync[0], enterKey};
		st_nxt.enterPrev = st_r.enterSync[1];
		st_nxt.in0Sync   = digitalIn;
		st_nxt.inSync    = st_r.in0Sync;
		// Millisecond prescaler; shared dwell and timeout base
		if (st_r.msTick == 32'(self_test_pkg::MS_CYCLES - 1)) begin
			st_nxt.msTick  = 32'h0;
			st_nxt.msCount = st_r.msCount + 32'h1;
		end else begin
			st_nxt.msTick = st_r.msTick + 32'h1;
		end

		// Register port, read data the cycle after the strobe
		st_nxt.rdata = 32'h0;
		if (regWrite) begin
			unique case (regAddr)
				self_test_pkg::REG_COMMAND:    st_nxt.command   = regWdata[7:0];
				self_test_pkg::REG_CONFIG:     st_nxt.config_   = regWdata[18:0];
				self_test_pkg::REG_LINE_TMO:   st_nxt.lineTmo   = regWdata[15:0];
				self_test_pkg::REG_BYPASS_TMO: st_nxt.bypassTmo = regWdata[15:0];
				default: ;
			endcase
		end
		if (regRead) begin
			unique case (regAddr)
				self_test_pkg::REG_COMMAND:    st_nxt.rdata = {24'h0, st_r.command};
				self_test_pkg::REG_CONFIG:     st_nxt.rdata = {13'h0, st_r.config_};
				self_test_pkg::REG_LINE_TMO:   st_nxt.rdata = {16'h0, st_r.lineTmo};
				self_test_pkg::REG_BYPASS_TMO: st_nxt.rdata = {16'h0, st_r.bypassTmo};
				self_test_pkg::REG_STATUS:     st_nxt.rdata = {10'h0, st_r.state, 1'b0,
					st_r.gateNum, st_r.display, st_r.faultCode[3:0]};
				self_test_pkg::REG_EVENT:      st_nxt.rdata = {16'h0, st_r.faultCode,
					st_r.eventNum};
				default:                       st_nxt.rdata = 32'h0;
			endcase
		end

		// Step dwell selection
		unique case (st_r.state)
			self_test_pkg::S_GATE: dwell = 32'(self_test_pkg::GATE_MS);
			self_test_pkg::S_ALL:  dwell = 32'(self_test_pkg::ALL_MS);
			self_test_pkg::S_DONE: dwell = 32'(self_test_pkg::DONE_MS);
			default:               dwell = 32'(self_test_pkg::DWELL_MS);
		endcase
		advance = enterPress || (st_r.msCount >= dwell);

		// Sequencer
		unique case (st_r.state)
			self_test_pkg::S_IDLE: begin
				st_nxt.drive = '0;
				if (st_r.command == self_test_pkg::STD_SELF_TEST_VALUE) begin
					st_nxt.eventNum   = self_test_pkg::EVT_SELF_TEST_ENTER;
					st_nxt.eventPulse = 1'b1;
					st_nxt.faultCode  = 8'h00;
					st_nxt.state      = self_test_pkg::S_WAIT_DISC;
				end
			end
			self_test_pkg::S_WAIT_DISC: begin
				st_nxt.msCount = 32'h0;
				if (st_r.discSync[1]) begin
					st_nxt.display = self_test_pkg::DSP_OPEN_DISC;
				end else if (st_r.lineTmo == 16'h0000) begin
					st_nxt.state   = self_test_pkg::S_BYP_ON;
					st_nxt.display = self_test_pkg::DSP_BYP_CLOSED;
				end else begin
					st_nxt.state   = self_test_pkg::S_LINE_ON;
					st_nxt.display = self_test_pkg::DSP_LINE_CLOSED;
				end
			end
			self_test_pkg::S_LINE_ON: begin
				st_nxt.drive.runRelay = 1'b1;
				if (lineUsed && !lineFb && st_r.msCount >= lineLimit) begin
					st_nxt.faultCode = self_test_pkg::FAULT_LINE;
					st_nxt.state     = self_test_pkg::S_HOLD;
				end else if (advance) begin
					st_nxt.state   = self_test_pkg::S_LINE_OFF;
					st_nxt.display = self_test_pkg::DSP_LINE_OPEN;
					st_nxt.msCount = 32'h0;
				end
			end
			self_test_pkg::S_LINE_OFF: begin
				st_nxt.drive.runRelay = 1'b0;
				if (lineUsed && lineFb && st_r.msCount >= lineLimit) begin
					st_nxt.faultCode = self_test_pkg::FAULT_LINE;
					st_nxt.state     = self_test_pkg::S_HOLD;
				end else if (advance) begin
					st_nxt.state   = self_test_pkg::S_BYP_ON;
					st_nxt.display = self_test_pkg::DSP_BYP_CLOSED;
					st_nxt.msCount = 32'h0;
				end
			end
			self_test_pkg::S_BYP_ON: begin
				st_nxt.drive.upToSpeedRelay = 1'b1;
				st_nxt.drive.bypassRelay = st_r.config_[self_test_pkg::CFG_BYP_ASG_BIT];
				// Fan duty without confirm input passes
				if (bypUsed && !bypFb && st_r.msCount >= bypLimit) begin
					st_nxt.faultCode = self_test_pkg::FAULT_BYPASS;
					st_nxt.state     = self_test_pkg::S_HOLD;
				end else if (advance) begin
					st_nxt.state   = self_test_pkg::S_BYP_OFF;
					st_nxt.display = self_test_pkg::DSP_BYP_OPEN;
					st_nxt.msCount = 32'h0;
				end
			end
			self_test_pkg::S_BYP_OFF: begin
				st_nxt.drive.upToSpeedRelay = 1'b0;
				st_nxt.drive.bypassRelay    = 1'b0;
				if (bypUsed && bypFb && st_r.msCount >= bypLimit) begin
					st_nxt.faultCode = self_test_pkg::FAULT_BYPASS;
					st_nxt.state     = self_test_pkg::S_HOLD;
				end else if (advance) begin
					st_nxt.state    = self_test_pkg::S_GATE;
					st_nxt.display  = self_test_pkg::DSP_GATE;
					st_nxt.gateStep = 3'h0;
					st_nxt.msCount  = 32'h0;
				end
			end
			self_test_pkg::S_GATE: begin
				st_nxt.drive.gates = gateOf(st_r.gateStep);
				st_nxt.drive.stringSel = {hv, 2'b11};
				st_nxt.gateNum = numOf(st_r.gateStep);
				if (advance) begin
					st_nxt.msCount = 32'h0;
					if (st_r.gateStep == 3'h5) begin
						st_nxt.state   = self_test_pkg::S_ALL;
						st_nxt.display = self_test_pkg::DSP_ALL;
						st_nxt.gateNum = 3'h0;
					end else begin
						st_nxt.gateStep = st_r.gateStep + 3'h1;
					end
				end
			end
			self_test_pkg::S_ALL: begin
				st_nxt.drive.gates     = 6'h3f;
				st_nxt.drive.stringSel = {hv, 2'b11};
				if (advance) begin
					st_nxt.drive      = '0;
					st_nxt.display    = self_test_pkg::DSP_DONE;
					st_nxt.eventNum   = self_test_pkg::EVT_SELF_TEST_PASS;
					st_nxt.eventPulse = 1'b1;
					st_nxt.msCount    = 32'h0;
					st_nxt.state      = self_test_pkg::S_DONE;
				end
			end
			self_test_pkg::S_DONE: begin
				if (st_r.msCount >= dwell) begin
					st_nxt.display     = self_test_pkg::DSP_HOME;
					st_nxt.systemReset = 1'b1;
					st_nxt.command     = 8'h00;
					st_nxt.state       = self_test_pkg::S_IDLE;
				end
			end
			self_test_pkg::S_HOLD: begin
				// Fault latched until command withdrawn
				st_nxt.drive = '0;
				if (st_r.command != self_test_pkg::STD_SELF_TEST_VALUE) begin
					st_nxt.display = self_test_pkg::DSP_HOME;
					st_nxt.state   = self_test_pkg::S_IDLE;
				end
			end
			default: st_nxt.state = self_test_pkg::S_IDLE;
		endcase

		// Cancel on disturbance; precedence over step flow
		if (active && st_r.state != self_test_pkg::S_WAIT_DISC) begin
			if (st_r.powerSync[1] && st_r.state == self_test_pkg::S_LINE_ON) begin
				st_nxt.faultCode = self_test_pkg::FAULT_SELF_TEST;
				st_nxt.state     = self_test_pkg::S_HOLD;
			end else if (st_r.discSync[1]) begin
				st_nxt.faultCode = self_test_pkg::FAULT_DISCONNECT;
				st_nxt.state     = self_test_pkg::S_HOLD;
			end else if (st_r.powerSync[1]) begin
				st_nxt.faultCode = self_test_pkg::FAULT_LINE_POWER;
				st_nxt.state     = self_test_pkg::S_HOLD;
			end
		end
		if (active && st_r.command != self_test_pkg::STD_SELF_TEST_VALUE) begin
			st_nxt.faultCode = self_test_pkg::FAULT_CMD_REMOVED;
			st_nxt.state     = self_test_pkg::S_HOLD;
		end
		if (st_nxt.state == self_test_pkg::S_HOLD && st_r.state != self_test_pkg::S_HOLD) begin
			st_nxt.drive      = '0;
			st_nxt.display    = self_test_pkg::DSP_HOME;  // No step shown while held
			st_nxt.eventNum   = st_nxt.faultCode;  // Fault logged as event
			st_nxt.eventPulse = 1'b1;
		end

		// Step timer restarts with each step; a free-running ms tick cut timeouts short
		if ((st_nxt.state != st_r.state) || (st_nxt.gateStep != st_r.gateStep)) begin
			st_nxt.msTick  = 32'h0;
			st_nxt.msCount = 32'h0;
		end

		// Relays, gates and gate number follow the next state, in step with the display
		st_nxt.drive   = '0;
		st_nxt.gateNum = 3'h0;
		unique case (st_nxt.state)
			self_test_pkg::S_LINE_ON: begin
				st_nxt.drive.runRelay = 1'b1;
			end
			self_test_pkg::S_BYP_ON: begin
				st_nxt.drive.upToSpeedRelay = 1'b1;
				st_nxt.drive.bypassRelay    = st_r.config_[self_test_pkg::CFG_BYP_ASG_BIT];
			end
			self_test_pkg::S_GATE: begin
				st_nxt.drive.gates     = gateOf(st_nxt.gateStep);
				st_nxt.drive.stringSel = {hv, 2'b11};
				st_nxt.gateNum         = numOf(st_nxt.gateStep);
			end
			self_test_pkg::S_ALL: begin
				st_nxt.drive.gates     = 6'h3f;
				st_nxt.drive.stringSel = {hv, 2'b11};
			end
			default: ;
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_r <= '{state: self_test_pkg::S_IDLE, display: self_test_pkg::DSP_HOME,
				config_: self_test_pkg::CFG_RESET, lineTmo: 16'h0000,
				bypassTmo: 16'h0000, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule

// [src/self_test_pkg.sv]
package self_test_pkg;

	// ****************************************************************
	// Command and event codes
	// ****************************************************************
	localparam logic [7:0] STD_SELF_TEST_VALUE = 8'h16;  // Command value 22
	localparam logic [7:0] EVT_SELF_TEST_ENTER = 8'hc1;  // Event 193
	localparam logic [7:0] EVT_SELF_TEST_PASS  = 8'hc3;  // Event 195
	localparam logic [7:0] FAULT_BYPASS        = 8'h30;  // Fault 48
	localparam logic [7:0] FAULT_LINE          = 8'h31;  // Fault 49
	localparam logic [7:0] FAULT_SELF_TEST     = 8'h32;  // Generic self-test fault
	localparam logic [7:0] FAULT_DISCONNECT    = 8'h33;
	localparam logic [7:0] FAULT_LINE_POWER    = 8'h34;
	localparam logic [7:0] FAULT_CMD_REMOVED   = 8'h35;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [3:0] REG_COMMAND    = 4'h0;  // Misc command parameter
	localparam logic [3:0] REG_CONFIG     = 4'h1;  // Confirm-input and voltage setup
	localparam logic [3:0] REG_LINE_TMO   = 4'h2;  // Line confirm timeout, ms, 0 = off
	localparam logic [3:0] REG_BYPASS_TMO = 4'h3;  // Bypass feedback timeout, ms
	localparam logic [3:0] REG_STATUS     = 4'h4;  // Display code and fault
	localparam logic [3:0] REG_EVENT      = 4'h5;  // Last event number
	localparam int CFG_LINE_SEL_LSB = 0;   // 8-bit mask of line-confirm inputs
	localparam int CFG_BYP_SEL_LSB  = 8;   // 8-bit mask of bypass-confirm inputs
	localparam int CFG_BYP_FAN_BIT  = 16;  // Dedicated bypass relay on fan duty
	localparam int CFG_BYP_ASG_BIT  = 17;  // Dedicated bypass relay assigned
	localparam int CFG_HV_BIT       = 18;  // 1 = 4160V, 0 = 2400V
	localparam logic [18:0] CFG_RESET = 19'h40000;

	// ****************************************************************
	// Timing: dwell per step, six gates plus four contactor halves
	// ****************************************************************
	localparam int CLK_HZ          = 20_000_000;
	localparam int TOTAL_SEC       = 285;
	localparam int DWELL_MS        = 25_000;  // Contactor halves, 4 x 25 s
	localparam int GATE_MS         = 25_000;  // Sequential gates, 6 x 25 s
	localparam int ALL_MS          = 35_000;  // All gates: 100+150+35 = 285 s
	localparam int DONE_MS         = 2_000;   // Completed message shown
	localparam int MS_CYCLES       = CLK_HZ / 1000;

	// Display codes
	typedef enum logic [3:0] {
		DSP_HOME = 4'h0, DSP_OPEN_DISC = 4'h1, DSP_LINE_CLOSED = 4'h2, DSP_LINE_OPEN = 4'h3,
		DSP_BYP_CLOSED = 4'h4, DSP_BYP_OPEN = 4'h5, DSP_GATE = 4'h6, DSP_ALL = 4'h7,
		DSP_DONE = 4'h8
	} display_t;

	typedef enum logic [9:0] {
		S_IDLE = 10'h001, S_WAIT_DISC = 10'h002, S_LINE_ON = 10'h004, S_LINE_OFF = 10'h008,
		S_BYP_ON = 10'h010, S_BYP_OFF = 10'h020, S_GATE = 10'h040, S_ALL = 10'h080,
		S_DONE = 10'h100, S_HOLD = 10'h200
	} state_t;

	typedef struct packed {
		logic       runRelay;
		logic       upToSpeedRelay;
		logic       bypassRelay;
		logic [5:0] gates;  // {p3b,p3a,p2b,p2a,p1b,p1a}
		logic [2:0] stringSel;  // A..F string positions fired: {E/F, C/D, A/B}
	} drive_t;

	typedef struct packed {
		state_t     state;
		logic [31:0] msTick;
		logic [31:0] msCount;
		logic [2:0] gateStep;
		display_t   display;
		logic [2:0] gateNum;
		logic [7:0] faultCode;
		logic [7:0] eventNum;
		logic       eventPulse;
		logic       systemReset;
		drive_t     drive;
		logic [7:0] command;
		logic [18:0] config_;
		logic [15:0] lineTmo;
		logic [15:0] bypassTmo;
		logic [31:0] rdata;
		logic [1:0] discSync;
		logic [1:0] powerSync;
		logic [1:0] enterSync;
		logic       enterPrev;
		logic [7:0] in0Sync;
		logic [7:0] inSync;
	} state_all_t;

endpackage

// [bench/contactor_feedback_model.sv]
`timescale 1ns/1ps
module contactor_feedback_model (
	input wire logic              sys_clk,
	input wire logic              reset,
	input self_test_pkg::drive_t  drive,
	input wire logic              stuckLine,
	input wire logic              stuckBypass,
	output logic [7:0]            digitalIn
);
	// ****************************************************************
	// Auxiliary contacts
	// ****************************************************************
	logic [3:0] lineDly_r;
	logic [3:0] bypDly_r;
	logic       noise_r;

	// Aux contacts lag the coils, as real mechanics do
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			lineDly_r <= 4'h0;
			bypDly_r  <= 4'h0;
			noise_r   <= 1'b0;
		end else begin
			lineDly_r <= {lineDly_r[2:0], drive.runRelay};
			bypDly_r  <= {bypDly_r[2:0], drive.upToSpeedRelay | drive.bypassRelay};
			noise_r   <= ~noise_r;
		end
	end

	// Input 01 line aux, 02 bypass aux; unwired inputs wander so masks matter
	assign digitalIn = {{6{noise_r}}, bypDly_r[3] & ~stuckBypass,
		lineDly_r[3] & ~stuckLine};
endmodule

// [bench/starter_self_test_chk.sv]
`timescale 1ns/1ps
module starter_self_test_chk (
	input wire logic                sys_clk,
	input wire logic                reset,
	input wire logic [3:0]          regAddr,
	input wire logic [31:0]         regWdata,
	input wire logic                regWrite,
	input wire logic                disconnectClosed,
	input wire logic                linePowerPresent,
	input self_test_pkg::drive_t    drive,
	input self_test_pkg::display_t  display,
	input wire logic [2:0]          gateNum,
	input wire logic [7:0]          eventNum,
	input wire logic                eventPulse,
	input wire logic [7:0]          faultCode,
	input wire logic                systemReset
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic active;

	// Gate bit behind each displayed gate number
	function automatic logic [5:0] gmask(input logic [2:0] n);
		case (n)
			3'h6: gmask = 6'h02;
			3'h3: gmask = 6'h01;
			3'h5: gmask = 6'h08;
			3'h2: gmask = 6'h04;
			3'h4: gmask = 6'h20;
			3'h1: gmask = 6'h10;
			default: gmask = 6'h00;
		endcase
	endfunction

	// Test steps in which a disturbance must abort
	assign active = display >= self_test_pkg::DSP_LINE_CLOSED
		&& display <= self_test_pkg::DSP_ALL && faultCode == 8'h00;

	AST_START_EVT: assert property (
		regWrite && regAddr == self_test_pkg::REG_COMMAND && regWdata[7:0] == 8'h16
		&& display == self_test_pkg::DSP_HOME && faultCode == 8'h00
		|-> ##[1:3] (eventPulse && eventNum == 8'hc1)) else $error("no entry event");
	AST_EVT_PULSE: assert property (
		eventPulse |=> !eventPulse) else $error("event pulse too long");
	AST_RST_PULSE: assert property (
		systemReset |=> !systemReset) else $error("system reset too long");
	AST_DISC_HOLD: assert property (
		display == self_test_pkg::DSP_OPEN_DISC |-> !drive.runRelay && drive.gates == 6'h00)
		else $error("ran with disconnect closed");
	AST_GATE_MAP: assert property (
		display == self_test_pkg::DSP_GATE |-> drive.gates == gmask(gateNum))
		else $error("wrong gate fired");
	AST_ALL_GATES: assert property (
		display == self_test_pkg::DSP_ALL |-> drive.gates == 6'h3f) else $error("gates off");
	AST_LINE_CYCLE: assert property (
		display == self_test_pkg::DSP_LINE_CLOSED |-> drive.runRelay) else $error("run off");
	AST_BYP_CYCLE: assert property (
		display == self_test_pkg::DSP_BYP_CLOSED |-> drive.upToSpeedRelay)
		else $error("bypass relay off");
	AST_DISC_ABORT: assert property (
		$rose(disconnectClosed) && active |-> ##[1:6] faultCode == 8'h33)
		else $error("no abort on disconnect");
	AST_POWER_FAULT: assert property (
		$rose(linePowerPresent) && active && display == self_test_pkg::DSP_LINE_CLOSED
		|-> ##[1:6] faultCode == 8'h32) else $error("no fault on line power");

	// Main scenarios reached
	cover property (display == self_test_pkg::DSP_ALL);
	cover property (display == self_test_pkg::DSP_GATE && gateNum == 3'h1);
	cover property (faultCode == 8'h31);
endmodule

bind starter_self_test_sequencer starter_self_test_chk starter_self_test_chk_inst (.sys_clk,
	.reset, .regAddr, .regWdata, .regWrite, .disconnectClosed, .linePowerPresent, .drive,
	.display, .gateNum, .eventNum, .eventPulse, .faultCode, .systemReset);

// [bench/starter_self_test_sequencer_bench.sv]
`timescale 1ns/1ps
module starter_self_test_sequencer_bench;
	// ****************************************************************
	// Design, far side and stimulus
	// ****************************************************************
	logic                    sys_clk, reset, regWrite, regRead, enterKey;
	logic                    disconnectClosed, linePowerPresent, stuckLine, stuckBypass;
	logic [3:0]              regAddr;
	logic [31:0]             regWdata, regRdata, rdVal;
	logic [7:0]              digitalIn, eventNum, faultCode;
	logic [2:0]              gateNum;
	logic                    eventPulse, systemReset;
	self_test_pkg::drive_t   drive;
	self_test_pkg::display_t display;
	int                      mismatches, check_count;
	logic [2:0]              gateSeq [6] = '{3'h6, 3'h3, 3'h5, 3'h2, 3'h4, 3'h1};
	logic [5:0]              gateBit [6] = '{6'h02, 6'h01, 6'h08, 6'h04, 6'h20, 6'h10};

	starter_self_test_sequencer starter_self_test_sequencer_inst (.sys_clk, .reset, .regAddr,
		.regWdata, .regWrite, .regRead, .regRdata, .disconnectClosed, .linePowerPresent,
		.enterKey, .digitalIn, .drive, .display, .gateNum, .eventNum, .eventPulse, .faultCode,
		.systemReset);
	contactor_feedback_model contactor_feedback_model_inst (.sys_clk, .reset, .drive,
		.stuckLine, .stuckBypass, .digitalIn);

	// 20 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Gap cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		tick(1);
		regWrite <= 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [3:0] a);
		regAddr <= a;
		regRead <= 1'b1;
		tick(1);
		regRead <= 1'b0;
		tick(1);
		rdVal = regRdata;  // Data stand only in the cycle after the strobe
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t ns: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic press(input int n);
		enterKey <= 1'b1;
		tick(1);
		enterKey <= 1'b0;
		tick(n);
	endtask
	task automatic expectEvent(input logic [7:0] ev);
		for (int i = 0; i < 12 && eventPulse !== 1'b1; i++) tick(1);
		chk(32'(eventPulse), 32'h1);
		chk(32'(eventNum), 32'(ev));
	endtask
	task automatic waitFault(input logic [7:0] f);
		for (int i = 0; i < 25000 && faultCode !== f; i++) tick(1);
		chk(32'(faultCode), 32'(f));
		chk(32'(eventNum), 32'(f));
	endtask
	// Fresh reset, setup, then the start command
	task automatic start(input logic [31:0] cfg, input logic [15:0] lt);
		reset <= 1'b1;
		tick(3);
		reset <= 1'b0;
		tick(1);
		wr(self_test_pkg::REG_CONFIG, cfg);
		wr(self_test_pkg::REG_LINE_TMO, {16'h0, lt});
		wr(self_test_pkg::REG_BYPASS_TMO, 32'h1);
		wr(self_test_pkg::REG_COMMAND, 32'h16);
		expectEvent(self_test_pkg::EVT_SELF_TEST_ENTER);
		tick(8);
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		{regWrite, regRead, enterKey, linePowerPresent, stuckLine, stuckBypass} = 6'h00;
		regAddr = 4'h0;
		regWdata = 32'h0;
		mismatches = 0;
		check_count = 0;
		disconnectClosed = 1'b1;
		reset = 1'b1;
		tick(12);
		reset <= 1'b0;
		tick(1);
		rd(self_test_pkg::REG_STATUS);
		chk(rdVal, 32'h1000);
		rd(self_test_pkg::REG_CONFIG);
		chk(rdVal, 32'(self_test_pkg::CFG_RESET));
		rd(4'hf);
		chk(rdVal, 32'h0);
		// Whole run: 2400V, line input 01, fan bypass without confirm input
		start(32'h10001, 16'h1);
		tick(40);
		chk(32'(display), 32'(self_test_pkg::DSP_OPEN_DISC));
		disconnectClosed <= 1'b0;
		tick(10);
		chk(32'(display), 32'(self_test_pkg::DSP_LINE_CLOSED));
		tick(21000);
		chk(32'(faultCode), 32'h0);
		press(8);
		chk(32'(display), 32'(self_test_pkg::DSP_LINE_OPEN));
		chk(32'(drive.runRelay), 32'h0);
		press(8);
		chk(32'(drive.upToSpeedRelay), 32'h1);
		tick(21000);
		chk(32'(faultCode), 32'h0);
		press(8);
		chk(32'(display), 32'(self_test_pkg::DSP_BYP_OPEN));
		for (int i = 0; i < 6; i++) begin
			press(8);
			chk(32'(gateNum), 32'(gateSeq[i]));
			chk(32'(drive.gates), 32'(gateBit[i]));
			chk(32'(drive.stringSel[2]), 32'h0);
		end
		press(8);
		chk(32'(display), 32'(self_test_pkg::DSP_ALL));
		press(0);
		expectEvent(self_test_pkg::EVT_SELF_TEST_PASS);
		tick(4);
		chk(32'(display), 32'(self_test_pkg::DSP_DONE));
		chk(32'(systemReset), 32'h0);
		// Line step off, command withdrawn in bypass step
		start(32'h40201, 16'h0);
		chk(32'(display), 32'(self_test_pkg::DSP_BYP_CLOSED));
		wr(self_test_pkg::REG_COMMAND, 32'h0);
		waitFault(self_test_pkg::FAULT_CMD_REMOVED);
		// 4160V gate step, then disconnect closes
		start(32'h40201, 16'h0);
		press(8);
		press(8);
		chk(32'(drive.stringSel[2]), 32'h1);
		disconnectClosed <= 1'b1;
		waitFault(self_test_pkg::FAULT_DISCONNECT);
		disconnectClosed <= 1'b0;
		// Line power while line contactor closed
		start(32'h40201, 16'h1);
		linePowerPresent <= 1'b1;
		waitFault(self_test_pkg::FAULT_SELF_TEST);
		linePowerPresent <= 1'b0;
		// Stuck line aux contact
		stuckLine <= 1'b1;
		start(32'h40201, 16'h1);
		waitFault(self_test_pkg::FAULT_LINE);
		stuckLine <= 1'b0;
		// Stuck bypass aux contact
		stuckBypass <= 1'b1;
		start(32'h40201, 16'h0);
		waitFault(self_test_pkg::FAULT_BYPASS);
		tally_and_finish();
	end

	// Watchdog well beyond the expected run of about 82000 cycles
	initial begin
		tick(95000);
		mismatches++;
		tally_and_finish();
	end
endmodule
